// File: hw/epo_output_card.sv
// eight-port output card: card select, port decode and port latches
`timescale 1ns/1ps

// Overview of operation
// - eight separately addressed ports, each holding one byte for outside equipment.
// - card select goes low only when every compare input matches this card.
// - address bits 12 and 13 compared true or inverted per jumper setting.
// - address bit 11 compared with polarity fixed by slot position; bits 14 and 15 must be low.
// - on the first cycle of a host strobe to this card, decoder enables exactly one of eight ports.
// - host strobe with data; card gates it by port enable into latch strobe.
// - strobe loads the byte into the selected port only; others keep theirs.
// - each port holds its byte until written again.
// - card answers one group of eight addresses within 0 to 63.
// - slots 0,1 take groups 0/16/32/48; slots 2,3 take 8/24/40/56 by jumper.
module epo_output_card
	import epo_pkg::*;
#(
	parameter int NUM_PORTS = EPO_NUM_PORTS,
	parameter int DATA_W    = EPO_DATA_W
) (
	input  wire logic                            i_mclk,
	input  wire logic                            i_arst_n,
	input  wire logic [EPO_ADDR_W-1:0]           i_io_address_lines,
	input  wire logic [DATA_W-1:0]               i_data,
	input  wire logic                            i_io_out_n,
	input  wire logic [EPO_SLOT_W-1:0]           i_slot_position,
	input  wire logic [EPO_JMP_W-1:0]            i_group_jumper,
	output logic                                 o_card_select_n,
	output logic      [NUM_PORTS-1:0]            o_port_latch_strobe,
	output logic      [NUM_PORTS-1:0][DATA_W-1:0] o_port_data
);

	// ****************************************
	// elaboration checks
	// ****************************************
	generate
		if (NUM_PORTS != 2**EPO_SEL_W) begin : g_bad_ports
			$error("port count must match the three-bit port select");
		end
		if (DATA_W != EPO_DATA_W) begin : g_bad_width
			$error("port width must match the bus data width");
		end
		if (EPO_ADDR_W != 8) begin : g_bad_addr_width
			$error("io address must span eight address lines");
		end
		if (EPO_PORT_MSB - EPO_PORT_LSB + 1 != EPO_SEL_W) begin : g_bad_port_field
			$error("port field must be as wide as the port select");
		end
		if (EPO_SLOT_ABIT != EPO_PORT_MSB + 1) begin : g_bad_slot_field
			$error("slot line must sit just above the port field");
		end
		if (EPO_JMP_MSB - EPO_JMP_LSB + 1 != EPO_JMP_W) begin : g_bad_jmp_width
			$error("jumper field must match the jumper width");
		end
		if (EPO_JMP_LSB != EPO_SLOT_ABIT + 1) begin : g_bad_jmp_field
			$error("jumper lines must sit just above the slot line");
		end
		if (EPO_HIGH_LSB != EPO_JMP_MSB + 1) begin : g_bad_high_field
			$error("fixed lines must sit just above the jumper lines");
		end
		if (EPO_HIGH_MSB != EPO_ADDR_W - 1) begin : g_bad_high_top
			$error("fixed lines must reach the top address line");
		end
		if ($bits(EPO_HIGH_VAL) != EPO_HIGH_MSB - EPO_HIGH_LSB + 1) begin : g_bad_high_val
			$error("fixed line value must match the fixed line count");
		end
		if (EPO_SLOT_GBIT >= EPO_SLOT_W) begin : g_bad_slot_bit
			$error("group bit must lie inside the slot code");
		end
		if ($bits(EPO_LATCH_RST) != DATA_W) begin : g_bad_latch_rst
			$error("latch reset value must match the port width");
		end
	endgenerate

	// ****************************************
	// pin synchronisers
	// ****************************************
	epo_bus_type   bus_s1_q;
	epo_bus_type   bus_s2_q;
	epo_bus_type   bus_in;
	epo_strap_type strap_s1_q;
	epo_strap_type strap_s2_q;
	epo_strap_type strap_in;
	epo_bus_type   bus_s1_d;
	epo_bus_type   bus_s2_d;
	epo_strap_type strap_s1_d;
	epo_strap_type strap_s2_d;

	always_comb begin
		bus_in.addr  = i_io_address_lines;
		bus_in.data  = i_data;
		bus_in.out_n = i_io_out_n;
		bus_s1_d     = bus_in;
		bus_s2_d     = bus_s1_q;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_s1_q <= EPO_BUS_IDLE;
			bus_s2_q <= EPO_BUS_IDLE;
		end else begin
			bus_s1_q <= bus_s1_d;
			bus_s2_q <= bus_s2_d;
		end
	end

	// straps settle two edges after reset
	always_comb begin
		strap_in.slot   = i_slot_position;
		strap_in.jumper = i_group_jumper;
		strap_s1_d      = strap_in;
		strap_s2_d      = strap_s1_q;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_s1_q <= EPO_STRAP_RST;
			strap_s2_q <= EPO_STRAP_RST;
		end else begin
			strap_s1_q <= strap_s1_d;
			strap_s2_q <= strap_s2_d;
		end
	end

	// ****************************************
	// address field views
	// ****************************************
	logic [EPO_SEL_W-1:0]               addr_port;
	logic                               addr_slot;
	logic [EPO_JMP_W-1:0]               addr_jmp;
	logic [EPO_HIGH_MSB-EPO_HIGH_LSB:0] addr_high;
	logic                               slot_odd;

	always_comb begin
		addr_port = bus_s2_q.addr[EPO_PORT_MSB:EPO_PORT_LSB];
		addr_slot = bus_s2_q.addr[EPO_SLOT_ABIT];
		addr_jmp  = bus_s2_q.addr[EPO_JMP_MSB:EPO_JMP_LSB];
		addr_high = bus_s2_q.addr[EPO_HIGH_MSB:EPO_HIGH_LSB];
		slot_odd  = strap_s2_q.slot[EPO_SLOT_GBIT];
	end

	// ****************************************
	// per-line compare
	// ****************************************
	logic [EPO_JMP_W-1:0]               jmp_bit_ok;
	logic [EPO_HIGH_MSB-EPO_HIGH_LSB:0] high_bit_ok;

	genvar b;
	generate
		for (b = 0; b < EPO_JMP_W; b++) begin : g_jmp
			assign jmp_bit_ok[b] = (addr_jmp[b] == strap_s2_q.jumper[b]);
		end
		for (b = 0; b <= EPO_HIGH_MSB - EPO_HIGH_LSB; b++) begin : g_high
			assign high_bit_ok[b] = (addr_high[b] == EPO_HIGH_VAL[b]);
		end
	endgenerate

	// ****************************************
	// module select compare
	// ****************************************
	logic                 high_ok;
	logic                 slot_ok;
	logic                 jmp_ok;
	logic                 card_hit;
	logic [EPO_SEL_W-1:0] port_sel;

	always_comb begin
		high_ok  = &high_bit_ok;
		slot_ok  = (addr_slot == slot_odd);
		jmp_ok   = &jmp_bit_ok;
		card_hit = high_ok && slot_ok && jmp_ok;
		port_sel = addr_port;
	end

	// ****************************************
	// strobe sequencer
	// ****************************************
	epo_state_type  state_q;
	epo_state_type  state_d;
	logic           dec_enable;
	logic [NUM_PORTS-1:0] port_en;
	logic           host_low;

	always_comb begin
		host_low   = !bus_s2_q.out_n;
		state_d    = state_q;
		dec_enable = 1'b0;
		case (state_q)
			EPO_ST_IDLE: begin
				if (host_low) begin
					dec_enable = card_hit;
					state_d    = EPO_ST_HELD;
				end
			end
			EPO_ST_HELD: begin
				// one load per host strobe
				if (!host_low) begin
					state_d = EPO_ST_IDLE;
				end
			end
			default: begin
				state_d = EPO_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q <= EPO_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// port decode
	// ****************************************
	epo_port_decoder #(
		.SEL_W (EPO_SEL_W)
	) u_dec (
		.i_enable  (dec_enable),
		.i_sel     (port_sel),
		.o_port_en (port_en)
	);

	// ****************************************
	// select and strobe outputs
	// ****************************************
	logic                 card_sel_n_q;
	logic                 card_sel_n_d;
	logic [NUM_PORTS-1:0] strobe_q;
	logic [NUM_PORTS-1:0] strobe_d;

	always_comb begin
		card_sel_n_d = !card_hit;
		strobe_d     = port_en;
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			card_sel_n_q <= 1'b1;
			strobe_q     <= '0;
		end else begin
			card_sel_n_q <= card_sel_n_d;
			strobe_q     <= strobe_d;
		end
	end

	assign o_card_select_n     = card_sel_n_q;
	assign o_port_latch_strobe = strobe_q;

	// ****************************************
	// port latches
	// ****************************************
	logic [NUM_PORTS-1:0][DATA_W-1:0] latch_q;
	logic [NUM_PORTS-1:0][DATA_W-1:0] latch_d;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic load_en;

			assign load_en = port_en[p];

			always_comb begin
				if (load_en) begin
					latch_d[p] = bus_s2_q.data;
				end else begin
					latch_d[p] = latch_q[p];
				end
			end

			always_ff @(posedge i_mclk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					latch_q[p] <= EPO_LATCH_RST;
				end else begin
					latch_q[p] <= latch_d[p];
				end
			end
		end
	endgenerate

	assign o_port_data = latch_q;

endmodule

// File: inc/epo_pkg.sv
// constants, carrier types and states shared by the eight-port output card
package epo_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int EPO_NUM_PORTS = 8;
	localparam int EPO_DATA_W    = 8;
	localparam int EPO_ADDR_W    = 8;
	localparam int EPO_SEL_W     = 3;
	localparam int EPO_SLOT_W    = 2;
	localparam int EPO_JMP_W     = 2;

	// ****************************************
	// io address field positions
	// ****************************************
	// port number within the card's group of eight
	localparam int EPO_PORT_LSB  = 0;
	localparam int EPO_PORT_MSB  = 2;
	// address line 11: fixed by slot position
	localparam int EPO_SLOT_ABIT = 3;
	// address lines 12 and 13: polarity by jumper
	localparam int EPO_JMP_LSB   = 4;
	localparam int EPO_JMP_MSB   = 5;
	// address lines 14 and 15: must both be low
	localparam int EPO_HIGH_LSB  = 6;
	localparam int EPO_HIGH_MSB  = 7;
	// slot code bit that picks the odd group of eight
	localparam int EPO_SLOT_GBIT = 1;

	// ****************************************
	// values
	// ****************************************
	localparam logic [1:0]            EPO_HIGH_VAL  = 2'h0;
	localparam logic [EPO_DATA_W-1:0] EPO_LATCH_RST = 8'h00;
	localparam logic [EPO_ADDR_W-1:0] EPO_ADDR_RST  = 8'h00;
	localparam logic [EPO_SLOT_W-1:0] EPO_SLOT_RST  = 2'h0;
	localparam logic [EPO_JMP_W-1:0]  EPO_JMP_RST   = 2'h0;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic [EPO_ADDR_W-1:0] addr;
		logic [EPO_DATA_W-1:0] data;
		logic                  out_n;
	} epo_bus_type;

	typedef struct packed {
		logic [EPO_SLOT_W-1:0] slot;
		logic [EPO_JMP_W-1:0]  jumper;
	} epo_strap_type;

	localparam epo_bus_type   EPO_BUS_IDLE  = '{addr: 8'h00, data: 8'h00, out_n: 1'b1};
	localparam epo_strap_type EPO_STRAP_RST = '{slot: 2'h0, jumper: 2'h0};

	typedef enum logic [1:0] {
		EPO_ST_IDLE = 2'h1,
		EPO_ST_HELD = 2'h2
	} epo_state_type;

endpackage

// File: hw/epo_port_decoder.sv
// three-to-eight port decoder with enable
`timescale 1ns/1ps
module epo_port_decoder
	import epo_pkg::*;
#(
	parameter int SEL_W = EPO_SEL_W
) (
	input  wire logic               i_enable,
	input  wire logic [SEL_W-1:0]   i_sel,
	output logic      [2**SEL_W-1:0] o_port_en
);

	// ****************************************
	// one enable per port
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2**SEL_W; g++) begin : g_dec
			assign o_port_en[g] = i_enable && (i_sel == SEL_W'(g));
		end
	endgenerate

endmodule

// File: tb/epo_output_card_assertions.sv
// assertions on the output card ports
`timescale 1ns/1ps
module epo_output_card_assertions
	import epo_pkg::*;
#(
	parameter int NUM_PORTS = 8,
	parameter int DATA_W    = 8
) (
	input wire logic										i_mclk,
	input wire logic										i_arst_n,
	input wire logic [EPO_ADDR_W-1:0]						i_io_address_lines,
	input wire logic [DATA_W-1:0]							i_data,
	input wire logic										i_io_out_n,
	input wire logic [EPO_SLOT_W-1:0]						i_slot_position,
	input wire logic [EPO_JMP_W-1:0]						i_group_jumper,
	input wire logic										o_card_select_n,
	input wire logic [NUM_PORTS-1:0]						o_port_latch_strobe,
	input wire logic [NUM_PORTS-1:0][DATA_W-1:0]			o_port_data
);
	logic [2:0]	age_q;
	logic [2:0]	age_d;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	function automatic logic hit(logic [7:0] a);
		return a[7:6] == 2'h0 && a[5:3] == {i_group_jumper, i_slot_position[1]};
	endfunction
	// cycles since reset, covers select latency
	always_comb age_d = (age_q == 3'h5) ? age_q : age_q + 3'h1;
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) age_q <= 3'h0;
		else age_q <= age_d;
	end
	AST_SEL_MATCH: assert property (age_q == 3'h5
		&& $past(i_io_address_lines, 3) == $past(i_io_address_lines, 4)
		|-> o_card_select_n == !hit($past(i_io_address_lines, 3))) else $error("select");
	AST_STB_SEL: assert property (|o_port_latch_strobe
		|-> !o_card_select_n && hit($past(i_io_address_lines, 3))) else $error("unselected");
	AST_STB_CAUSE: assert property (|o_port_latch_strobe |-> !$past(i_io_out_n, 3))
		else $error("no host cycle");
	AST_ONE_HOT: assert property (|o_port_latch_strobe |-> $onehot(o_port_latch_strobe))
		else $error("several ports");
	AST_PORT_PICK: assert property (|o_port_latch_strobe
		|-> o_port_latch_strobe == 8'h01 << $past(i_io_address_lines[2:0], 3)) else $error("port");
	AST_DATA_LOAD: assert property (|o_port_latch_strobe
		|-> o_port_data[$past(i_io_address_lines[2:0], 3)] == $past(i_data, 3)) else $error("byte");
	AST_HOLD: assert property (o_port_latch_strobe == 8'h00 |-> $stable(o_port_data))
		else $error("data moved");
	AST_PULSE: assert property (|o_port_latch_strobe |=> o_port_latch_strobe == 8'h00)
		else $error("long strobe");
endmodule
bind epo_output_card epo_output_card_assertions #(.NUM_PORTS(NUM_PORTS), .DATA_W(DATA_W)) i_chk (.*);

// File: tb/epo_host_model.sv
// host model driving output cycles onto the card
`timescale 1ns/1ps
module epo_host_model
	import epo_pkg::*;
(
	input wire logic	i_mclk,
	output epo_bus_type	o_bus
);
	initial o_bus = EPO_BUS_IDLE;
	task automatic write(input logic [7:0] a, input logic [7:0] d, input int gap);
		@(negedge i_mclk);
		o_bus.addr = a;
		o_bus.data = d;
		repeat (3 + gap) @(negedge i_mclk);
		o_bus.out_n = 1'b0;
		repeat (2) @(negedge i_mclk);
		o_bus.out_n = 1'b1;
		repeat (2) @(negedge i_mclk);
		// released lines show the inverse
		o_bus.addr = ~a;
		o_bus.data = ~d;
	endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the output card
`timescale 1ns/1ps
module tb_top;
	import epo_pkg::*;
	logic				i_mclk = 1'b0;
	logic				i_arst_n = 1'b0;
	logic [1:0]			i_slot_position = 2'h0;
	logic [1:0]			i_group_jumper = 2'h0;
	logic [7:0]			i_io_address_lines;
	logic [7:0]			i_data;
	logic				i_io_out_n;
	logic				o_card_select_n;
	logic [7:0]			o_port_latch_strobe;
	logic [7:0][7:0]	o_port_data;
	logic [7:0][7:0]	sh;
	logic [7:0]			base;
	logic [31:0]		seed = 32'h2889;
	logic [72:0]		q [$];
	epo_bus_type		bus;
	int					err_total = 0;
	int					n_tests = 0;
	wire [72:0]			seen = {o_card_select_n, o_port_latch_strobe, o_port_data};
	assign {i_io_address_lines, i_data, i_io_out_n} = bus;
	always #10 i_mclk = ~i_mclk;
	epo_host_model i_host (.i_mclk(i_mclk), .o_bus(bus));
	epo_output_card i_dut (.*);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [72:0] e, input logic [72:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// expected image noted only for hits of this card
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a[7:6] == 2'h0 && a[5:3] == {i_group_jumper, i_slot_position[1]}) begin
			sh[a[2:0]] = d;
			q.push_back({1'b0, 8'h01 << a[2:0], sh});
		end
		i_host.write(a, d, int'(xs() & 32'h3));
	endtask
	always @(negedge i_mclk) begin
		if (i_arst_n && o_port_latch_strobe !== 8'h00) chk("write", (q.size() > 0) ? q.pop_front() : 73'h0, seen);
	end
	initial begin
		for (int c = 0; c < 16; c++) begin
			@(negedge i_mclk);
			i_arst_n = 1'b0;
			{i_slot_position, i_group_jumper} = 4'(c);
			sh = '0;
			repeat (20) @(negedge i_mclk);
			chk("reset", {1'b1, 72'h0}, seen);
			i_arst_n = 1'b1;
			base = {2'h0, i_group_jumper, i_slot_position[1], 3'h0};
			for (int p = 0; p < 8; p++) wr(base + 8'(p), 8'(xs()));
			for (int k = 0; k < 8; k++) wr(8'(xs()), 8'(xs()));
			wr(base ^ 8'h0A, 8'h5A);
			wr(base | 8'h42, 8'h3C);
			wr(base | 8'h07, 8'hC3);
		end
		repeat (9) @(negedge i_mclk);
		chk("queue", 73'h0, 73'(q.size()));
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge i_mclk);
		err_total++;
		wrap_up();
	end
endmodule
